// File: src/pcp_ctl.sv
// pcp_ctl: requester end; software orders fetch, table read, verify
// and program operations through AXI4-Lite registers.
// assumes: one clk, rst_n synchronous active low; one op in flight.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
module pcp_ctl (
  input wire logic clk,
  input wire logic rst_n,
  pcp_if.ctl link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [pcp_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  typedef struct packed {
    logic aw_held;
    logic [pcp_pkg::AXI_AW-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic req_valid;
    pcp_pkg::pcp_op_e op;
    logic from_ext;
    logic [pcp_pkg::ADDR_W-1:0] addr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic ea_n;
    logic busy;
    logic done;
    logic refused;
  } pcp_ctl_s;

  pcp_ctl_s st_reg;
  pcp_ctl_s st_next;

  // byte-lane merge for a strobed register write
  function automatic logic [31:0] strb_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus handshakes

  // address and data are held apart so either may come first
  assign s_axi_awready = ~st_reg.aw_held & ~st_reg.bvalid;
  assign s_axi_wready = ~st_reg.w_held & ~st_reg.bvalid;
  assign s_axi_arready = ~st_reg.rvalid;

  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // link: request stands until taken, answer ends the busy phase
    if (st_reg.req_valid && link.req_ready) begin
      st_next.req_valid = 1'b0;
    end
    if (link.rsp_valid) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
      st_next.refused = link.rsp_refused;
      st_next.rbyte = link.rsp_data;
    end
    // register write once both halves are in
    if (st_reg.aw_held && st_reg.w_held) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = pcp_pkg::RESP_OKAY;
      case (st_reg.awaddr)
        pcp_pkg::REG_CMD: begin
          // a command while busy is refused, not queued
          if (st_reg.busy) begin
            st_next.bresp = pcp_pkg::RESP_SLVERR;
          end else if (st_reg.wstrb[0]) begin
            st_next.op = pcp_pkg::pcp_op_e'(st_reg.wdata[1:0]);
            st_next.from_ext = st_reg.wdata[pcp_pkg::CMD_EXT_BIT];
            st_next.req_valid = 1'b1;
            st_next.busy = 1'b1;
            st_next.done = 1'b0;
          end
        end
        pcp_pkg::REG_ADDR: begin
          st_next.addr = pcp_pkg::ADDR_W'(strb_merge(
            32'(st_reg.addr), st_reg.wdata, st_reg.wstrb));
        end
        pcp_pkg::REG_WDATA: begin
          if (st_reg.wstrb[0]) begin
            st_next.wbyte = st_reg.wdata[7:0];
          end
        end
        pcp_pkg::REG_PIN: begin
          if (st_reg.wstrb[0]) begin
            st_next.ea_n = st_reg.wdata[0];
          end
        end
        pcp_pkg::REG_STATUS, pcp_pkg::REG_RDATA: begin
          st_next.bresp = pcp_pkg::RESP_OKAY; // read only, write ignored
        end
        default: begin
          st_next.bresp = pcp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // register read, answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = pcp_pkg::RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        pcp_pkg::REG_CMD: st_next.rdata = 32'({st_reg.from_ext, st_reg.op});
        pcp_pkg::REG_ADDR: st_next.rdata = 32'(st_reg.addr);
        pcp_pkg::REG_WDATA: st_next.rdata = 32'(st_reg.wbyte);
        pcp_pkg::REG_STATUS: begin
          st_next.rdata[pcp_pkg::ST_BUSY] = st_reg.busy;
          st_next.rdata[pcp_pkg::ST_DONE] = st_reg.done;
          st_next.rdata[pcp_pkg::ST_REFUSED] = st_reg.refused;
        end
        pcp_pkg::REG_RDATA: st_next.rdata = 32'(st_reg.rbyte);
        pcp_pkg::REG_PIN: st_next.rdata = 32'(st_reg.ea_n);
        default: st_next.rresp = pcp_pkg::RESP_SLVERR;
      endcase
    end
    if (!rst_n) begin
      st_next = '0;
      st_next.ea_n = 1'b1; // internal execution after reset
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign link.req_valid = st_reg.req_valid;
  assign link.req_op = st_reg.op;
  assign link.req_addr = st_reg.addr;
  assign link.req_wdata = st_reg.wbyte;
  assign link.req_from_ext = st_reg.from_ext;
  assign link.ext_access_n = st_reg.ea_n;

endmodule

// File: src/pcp_pkg.sv
// pcp_pkg: shared constants and types for the code protection block.
// assumes: included first; both ends and the link use these names.
package pcp_pkg;

  // request address reaches the option byte of the 64K image
  localparam int ADDR_W = 17;
  localparam int KEY_BYTES = 64;
  localparam int KEY_IDX_W = 6;
  localparam int OPT_REL = 32'h0000_0040;
  localparam int LOCK1_BIT = 0;
  localparam int LOCK2_BIT = 1;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;

  // user code sizes; key starts right after code
  localparam int SIZE_8K = 32'h0000_2000;
  localparam int SIZE_16K = 32'h0000_4000;
  localparam int SIZE_32K = 32'h0000_8000;
  localparam int SIZE_64K = 32'h0001_0000;

  typedef enum logic [1:0] {
    PCP_OP_FETCH = 2'b00,
    PCP_OP_TABLE = 2'b01,
    PCP_OP_VERIFY = 2'b10,
    PCP_OP_PROGRAM = 2'b11
  } pcp_op_e;

  // controller registers, byte offsets on the AXI4-Lite bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_PIN = 8'h14;
  localparam int CMD_EXT_BIT = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic size_ok(input int n);
    return n == SIZE_8K || n == SIZE_16K || n == SIZE_32K || n == SIZE_64K;
  endfunction

endpackage

// File: src/pcp_if.sv
// pcp_if: link between the protected memory and its requester.
// assumes: both ends on clk; ext_access_n is a pin level from the
// requester side, so the device synchronises it.
`timescale 1ns/10ps
interface pcp_if (
  input wire logic clk
);
  logic req_valid;
  logic req_ready;
  pcp_pkg::pcp_op_e req_op;
  logic [pcp_pkg::ADDR_W-1:0] req_addr;
  logic [7:0] req_wdata;
  logic req_from_ext;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_refused;
  logic ext_access_n;

  modport dev (
    input req_valid,
    output req_ready,
    input req_op,
    input req_addr,
    input req_wdata,
    input req_from_ext,
    output rsp_valid,
    output rsp_data,
    output rsp_refused,
    input ext_access_n
  );

  modport ctl (
    output req_valid,
    input req_ready,
    output req_op,
    output req_addr,
    output req_wdata,
    output req_from_ext,
    input rsp_valid,
    input rsp_data,
    input rsp_refused,
    output ext_access_n
  );
endinterface

// File: src/pcp_dev.sv
// pcp_dev: program memory image (code, key, option byte) with the
// protection logic that guards fetch, table read, verify and program.
// assumes: one clk, rst_n synchronous active low; requests come over
// pcp_if and each is answered one cycle after it is taken.
//
// Contract
// - unlocked part lets verify read code
// - key present encrypts every verify read
// - lock one blocks external table reads
// - lock one latches access pin at reset
// - lock one refuses all programming
// - both locks also disable verify
// - key array 64 bytes, blank ones
// - all-ones key leaves code unchanged
// - option bit0 lock one, bit1 two, 0=on
// - lock two never set without one
// - other lock combinations are undefined
// - 8K image: key 2000h, option 2040h
// - 16K image: key 4000h, option 4040h
// - 32K image: key 8000h, option 8040h
// - 64K image: key 10000h, option 10040h
`timescale 1ns/10ps
module pcp_dev #(
  parameter int MEM_BYTES = pcp_pkg::SIZE_8K
) (
  input wire logic clk,
  input wire logic rst_n,
  pcp_if.dev link,
  output logic ext_access_n,
  output logic lock_one,
  output logic lock_two,
  output logic key_present
);

  ////////////////////////////////////////////////////////////////////
  // image layout

  // key right after user code, option byte 40h past the key base
  localparam int KEY_BASE = MEM_BYTES;
  localparam int OPT_ADDR = MEM_BYTES + pcp_pkg::OPT_REL;
  localparam int IMG_BYTES = OPT_ADDR + 1;
  localparam int IDX_W = $clog2(IMG_BYTES);

  // only the four documented sizes have a defined layout
  if (!pcp_pkg::size_ok(MEM_BYTES)) begin : g_bad_size
    $error("MEM_BYTES must be 8K, 16K, 32K or 64K");
  end

  typedef struct packed {
    logic ea_s1;
    logic ea_s2;
    logic ea_latch;
    logic lock1;
    logic lock2;
    logic key_set;
    logic rsp_valid;
    logic rsp_refused;
    logic [7:0] rsp_data;
  } pcp_dev_s;

  pcp_dev_s st_reg;
  pcp_dev_s st_next;

  // nonvolatile image: starts erased, bits only ever go from 1 to 0
  logic [7:0] mem [IMG_BYTES] = '{default: pcp_pkg::BLANK_BYTE};

  logic accept;
  logic in_code;
  logic in_img;
  logic key_any;
  logic prog_ok;
  logic [IDX_W-1:0] idx;
  logic [7:0] code_byte;
  logic [7:0] key_byte;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // verify output: a blank key byte gives the code back unchanged
  function automatic logic [7:0] encrypt_byte(
    input logic [7:0] code,
    input logic [7:0] key
  );
    return ~(code ^ key);
  endfunction

  // option bit low means that protection is on
  function automatic logic opt_on(
    input logic [7:0] opt,
    input int bit_pos
  );
    return ~opt[bit_pos];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // request decode

  // ready only out of reset, so a request is never half taken
  assign link.req_ready = rst_n;
  assign accept = link.req_valid & link.req_ready;
  assign in_code = link.req_addr < pcp_pkg::ADDR_W'(MEM_BYTES);
  assign in_img = link.req_addr < pcp_pkg::ADDR_W'(IMG_BYTES);
  assign idx = link.req_addr[IDX_W-1:0];
  assign code_byte = mem[idx];
  assign key_byte = mem[IDX_W'(KEY_BASE) +
    IDX_W'(link.req_addr[pcp_pkg::KEY_IDX_W-1:0])];
  // programming stays open only while lock one is off
  assign prog_ok = accept & (link.req_op == pcp_pkg::PCP_OP_PROGRAM) &
    ~st_reg.lock1 & in_img;

  // any key byte away from all ones means a key is present
  always_comb begin
    key_any = 1'b0;
    for (int i = 0; i < pcp_pkg::KEY_BYTES; i++) begin
      if (mem[KEY_BASE + i] != pcp_pkg::BLANK_BYTE) begin
        key_any = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state update

  // all protection state is one record; reset reloads locks and key from the image, the pin latch from the pin
  always_comb begin
    st_next = st_reg;
    st_next.ea_s1 = link.ext_access_n;
    st_next.ea_s2 = st_reg.ea_s1;
    st_next.rsp_valid = 1'b0;
    if (!rst_n) begin
      // settings take effect only at reset, never mid-run
      st_next.lock1 = opt_on(mem[OPT_ADDR], pcp_pkg::LOCK1_BIT);
      st_next.lock2 = opt_on(mem[OPT_ADDR], pcp_pkg::LOCK2_BIT);
      st_next.key_set = key_any;
      st_next.ea_latch = st_reg.ea_s2;
      st_next.rsp_refused = 1'b0;
      st_next.rsp_data = 8'h00;
    end else if (accept) begin
      st_next.rsp_valid = 1'b1;
      st_next.rsp_refused = 1'b0;
      st_next.rsp_data = pcp_pkg::BLOCKED_BYTE;
      case (link.req_op)
        pcp_pkg::PCP_OP_FETCH: begin
          // core fetch of own code is never restricted here
          if (in_code) begin
            st_next.rsp_data = code_byte;
          end else begin
            st_next.rsp_refused = 1'b1;
          end
        end
        pcp_pkg::PCP_OP_TABLE: begin
          if (!in_code) begin
            st_next.rsp_refused = 1'b1;
          end else if (st_reg.lock1 && link.req_from_ext) begin
            // fixed byte and no fault, so the core just runs on
            st_next.rsp_data = pcp_pkg::BLOCKED_BYTE;
          end else begin
            st_next.rsp_data = code_byte;
          end
        end
        pcp_pkg::PCP_OP_VERIFY: begin
          // lock two alone is undefined; it is given no effect here
          if (st_reg.lock1 && st_reg.lock2) begin
            st_next.rsp_refused = 1'b1;
          end else if (!in_code) begin
            // key and option byte must never leak through verify
            st_next.rsp_refused = 1'b1;
          end else if (st_reg.key_set) begin
            st_next.rsp_data = encrypt_byte(code_byte, key_byte);
          end else begin
            st_next.rsp_data = code_byte;
          end
        end
        pcp_pkg::PCP_OP_PROGRAM: begin
          st_next.rsp_refused = ~prog_ok;
          st_next.rsp_data = prog_ok ? (code_byte & link.req_wdata) :
            pcp_pkg::BLOCKED_BYTE;
        end
        default: begin
          st_next.rsp_refused = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // image write; a program pulse can only clear bits
  always_ff @(posedge clk) begin
    if (rst_n && prog_ok) begin
      mem[idx] <= code_byte & link.req_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign link.rsp_valid = st_reg.rsp_valid;
  assign link.rsp_data = st_reg.rsp_data;
  assign link.rsp_refused = st_reg.rsp_refused;
  // locked: later pin changes are ignored until the next reset
  assign ext_access_n = st_reg.lock1 ? st_reg.ea_latch : st_reg.ea_s2;
  assign lock_one = st_reg.lock1;
  assign lock_two = st_reg.lock2;
  assign key_present = st_reg.key_set;

endmodule

// File: tb/pcp_asserts.sv
// pcp_asserts: link checks for the code protection pair.
// assumes: sits beside pcp_if in the bench; one clk, rst_n sync low.
`timescale 1ns/10ps
module pcp_chk #(
  parameter int MEM_BYTES = pcp_pkg::SIZE_8K
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pcp_pkg::pcp_op_e req_op,
  input wire logic [pcp_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_from_ext,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_refused,
  input wire logic lock_one,
  input wire logic lock_two,
  input wire logic key_present,
  input wire logic ext_access_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // request taken at this edge, and whether it points into code
  logic take;
  logic in_code;
  assign take = req_valid && req_ready;
  assign in_code = 32'(req_addr) < MEM_BYTES;

  ////////////////////////////////////////////////////////////////////////
  // every answer comes the cycle after its request, never otherwise
  a_answer_next: assert property (take |=> rsp_valid)
    else $error("no answer after a taken request");
  a_answer_cause: assert property (rsp_valid |-> $past(take))
    else $error("answer without a request");
  a_refused_zero: assert property (
    rsp_valid && rsp_refused |-> rsp_data == 8'h00)
    else $error("refused answer carries data");
  // settings only move while reset is low
  a_locks_held: assert property (
    $stable({lock_one, lock_two, key_present}))
    else $error("protection latches changed outside reset");
  a_verify_locked: assert property (
    take && req_op == pcp_pkg::PCP_OP_VERIFY && lock_one && lock_two
    |=> rsp_valid && rsp_refused) else $error("locked verify answered");
  a_program_locked: assert property (
    take && req_op == pcp_pkg::PCP_OP_PROGRAM && lock_one
    |=> rsp_refused) else $error("locked program accepted");
  a_table_blocked: assert property (
    take && req_op == pcp_pkg::PCP_OP_TABLE && req_from_ext && lock_one
    && in_code |=> !rsp_refused && rsp_data == pcp_pkg::BLOCKED_BYTE)
    else $error("external table read not blocked");
  a_key_not_code: assert property (
    take && req_op == pcp_pkg::PCP_OP_VERIFY && !in_code
    |=> rsp_refused) else $error("verify read past code area");
  a_open_verify: assert property (
    take && req_op == pcp_pkg::PCP_OP_VERIFY && !lock_one && in_code
    |=> !rsp_refused) else $error("open verify refused");
  // a latched pin must not follow later pin changes
  a_pin_latched: assert property (
    lock_one |=> $stable(ext_access_n))
    else $error("latched access pin moved");
endmodule

// File: tb/program_memory_code_protection_bench.sv
// bench: software orders ops through pcp_ctl, pcp_dev answers.
// assumes: 8K image that keeps its contents across resets.
`timescale 1ns/10ps
module program_memory_code_protection_bench;
  localparam logic [2:0] FET = {1'b0, pcp_pkg::PCP_OP_FETCH};
  localparam logic [2:0] TBL = {1'b0, pcp_pkg::PCP_OP_TABLE};
  localparam logic [2:0] TBX = {1'b1, pcp_pkg::PCP_OP_TABLE};
  localparam logic [2:0] VER = {1'b0, pcp_pkg::PCP_OP_VERIFY};
  localparam logic [2:0] PRG = {1'b0, pcp_pkg::PCP_OP_PROGRAM};
  logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_access_n;
  logic lock_one, lock_two, key_present;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int errors, compares;

  ////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  pcp_if link (.clk(clk));
  pcp_dev #(.MEM_BYTES(pcp_pkg::SIZE_8K)) pcp_dev_i (.clk(clk),
    .rst_n(rst_n), .link(link), .ext_access_n(ext_access_n),
    .lock_one(lock_one), .lock_two(lock_two), .key_present(key_present));
  pcp_ctl pcp_ctl_i (.clk(clk), .rst_n(rst_n), .link(link),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));
  pcp_chk #(.MEM_BYTES(pcp_pkg::SIZE_8K)) pcp_chk_i (.clk(clk),
    .rst_n(rst_n), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_op(link.req_op),
    .req_addr(link.req_addr), .req_from_ext(link.req_from_ext),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
    .rsp_refused(link.rsp_refused), .lock_one(lock_one),
    .lock_two(lock_two), .key_present(key_present),
    .ext_access_n(ext_access_n));

  ////////////////////////////////////////////////////////////////////////
  // judging and closing
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic hung(input string what);
    errors++;
    $display("mismatch %s expected answer seen none", what);
    test_done();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus cycles; each starts after an edge so no signal is set twice
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 20) hung("write response");
    s_axi_bready <= 1'b0;
    check("write resp", 32'(s_axi_bresp), 32'(pcp_pkg::RESP_OKAY));
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 20) hung("read data");
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  // one link operation ordered by software, answer judged
  task automatic op_run(input logic [2:0] cmd, input logic [16:0] a,
      input logic [7:0] wd, exp_d, input logic exp_r);
    int n;
    axi_wr(pcp_pkg::REG_ADDR, 32'(a));
    axi_wr(pcp_pkg::REG_WDATA, 32'(wd));
    axi_wr(pcp_pkg::REG_CMD, 32'(cmd));
    for (n = 0; n < 20; n++) begin
      axi_rd(pcp_pkg::REG_STATUS, rd);
      if (rd[pcp_pkg::ST_DONE] === 1'b1) break;
    end
    if (n == 20) hung("op done");
    check("refused", 32'(rd[pcp_pkg::ST_REFUSED]), 32'(exp_r));
    axi_rd(pcp_pkg::REG_RDATA, rd);
    check("answer byte", rd, 32'(exp_d));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_blank();
    check("lock one", 32'(lock_one), 32'h0);
    check("key present", 32'(key_present), 32'h0);
    op_run(VER, 17'h0003f, 8'h00, 8'hff, 1'b0);
    op_run(VER, 17'h02005, 8'h00, 8'h00, 1'b1);
    op_run(FET, 17'h02000, 8'h00, 8'h00, 1'b1);
    op_run(PRG, 17'h0003f, 8'h3c, 8'h3c, 1'b0);
    op_run(VER, 17'h0003f, 8'h00, 8'h3c, 1'b0);
    op_run(TBX, 17'h0003f, 8'h00, 8'h3c, 1'b0);
    axi_rd(8'h40, rd);
    check("unmapped resp", 32'(rr), 32'(pcp_pkg::RESP_SLVERR));
    $display("blank test done");
  endtask

  // register readback; relies on the last op of the blank test
  task automatic t_regs();
    axi_wr(pcp_pkg::REG_ADDR, 32'h0001_2345);
    axi_rd(pcp_pkg::REG_ADDR, rd);
    check("addr reg", rd, 32'h0001_2345);
    check("read resp", 32'(rr), 32'(pcp_pkg::RESP_OKAY));
    axi_rd(pcp_pkg::REG_PIN, rd);
    check("pin reg", rd, 32'h0000_0001);
    axi_rd(pcp_pkg::REG_CMD, rd);
    check("cmd reg", rd, 32'(TBX));
    // status is read only: a write is ignored and answered okay
    axi_wr(pcp_pkg::REG_STATUS, 32'h0000_0000);
    axi_rd(pcp_pkg::REG_STATUS, rd);
    check("status reg", rd, 32'h0000_0002);
    $display("register test done");
  endtask

  // pin follows software unless lock one latched it in reset
  task automatic t_pin(input logic locked);
    axi_wr(pcp_pkg::REG_PIN, 32'h0);
    repeat (5) @(posedge clk);
    check("pin", 32'(ext_access_n), 32'(locked));
    axi_wr(pcp_pkg::REG_PIN, 32'h1);
    $display("pin test done");
  endtask

  task automatic t_key();
    op_run(PRG, 17'h0203f, 8'h0f, 8'h0f, 1'b0);
    op_run(PRG, 17'h00040, 8'h5a, 8'h5a, 1'b0);
    do_reset();
    check("key present", 32'(key_present), 32'h1);
    op_run(VER, 17'h0003f, 8'h00, 8'hcc, 1'b0);
    op_run(VER, 17'h00040, 8'h00, 8'h5a, 1'b0);
    $display("key test done");
  endtask

  task automatic t_lock();
    // lock two is only ever set together with lock one
    op_run(PRG, 17'h02040, 8'hfc, 8'hfc, 1'b0);
    do_reset();
    check("lock one", 32'(lock_one), 32'h1);
    check("lock two", 32'(lock_two), 32'h1);
    op_run(TBX, 17'h0003f, 8'h00, pcp_pkg::BLOCKED_BYTE, 1'b0);
    op_run(TBL, 17'h0003f, 8'h00, 8'h3c, 1'b0);
    op_run(PRG, 17'h0003f, 8'h00, 8'h00, 1'b1);
    op_run(FET, 17'h0003f, 8'h00, 8'h3c, 1'b0);
    op_run(VER, 17'h0003f, 8'h00, 8'h00, 1'b1);
    t_pin(1'b1);
    $display("lock test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    errors = 0;
    compares = 0;
    do_reset();
    t_blank();
    t_regs();
    t_pin(1'b0);
    t_key();
    t_lock();
    test_done();
  end
endmodule
